// >>> design/ihim_top.sv
// What this block does
// - Drive a separate three-line power setting code for each coil half.
// - Drive one energize permit per coil half; energize only while permitted.
// - Drive one line requesting a change of heating duty ratio.
// - Board reports on two status lines; first high, second low means healthy.
// - Status arrives through an optical isolator and is decoded here.
// - At power-up or both covers closing, both low means C471, counter 11.
// - In normal running, both low means supply loss, C472, counter 12.
// - In normal running, first low second high means switch fault, C480, 15.
// - Board gives low-high when one half conducts 15 seconds or longer.
// - In normal running, both high means input current too low, C490, 17.
// - With a cover open, both low decodes as C475, counter 10; other patterns as above.
// - On any fault remove coil energization and raise a service call.
// - During warm-up with feeder scanning, lower the power setting 50 W.
// - Error-status counter always holds a value from 0 to 29.
// - After repair and power-up the error-status counter returns to zero.
`timescale 1ns/100ps
`include "ihim_defines.svh"
module ihim_top #(
    parameter int INIT_CHECK_CYCLES = `IHIM_INIT_CHECK_US * `IHIM_CLK_MHZ
) (
    input wire logic SYS_CLK_I,
    input wire logic RSTN_I,
    input wire logic HEATER_STATUS_LINE_A_I,
    input wire logic HEATER_STATUS_LINE_B_I,
    input wire logic FRONT_COVER_CLOSED_I,
    input wire logic JAM_COVER_CLOSED_I,
    input wire logic [2:0] HALF_A_POWER_LEVEL_I,
    input wire logic [2:0] HALF_B_POWER_LEVEL_I,
    input wire logic HALF_A_HEAT_REQ_I,
    input wire logic HALF_B_HEAT_REQ_I,
    input wire logic DUTY_CHANGE_I,
    input wire logic WARM_UP_I,
    input wire logic FEEDER_SCAN_I,
    input wire logic ERR_CLEAR_I,
    output logic [2:0] HALF_A_POWER_SEL_O,
    output logic [2:0] HALF_B_POWER_SEL_O,
    output logic HALF_A_ENERGIZE_PERMIT_O,
    output logic HALF_B_ENERGIZE_PERMIT_O,
    output logic DUTY_CHANGE_REQUEST_O,
    output logic SERVICE_CALL_O,
    output logic ERROR_EVENT_O,
    output logic [15:0] ERROR_CODE_O,
    output logic [4:0] ERROR_COUNT_O,
    output logic [1:0] CHECK_MODE_O
);
    ihim_status_if st ();

    ihim_pkg::ihim_mode_e mode_reg;
    ihim_pkg::ihim_mode_e mode_next;
    ihim_pkg::ihim_decode_s dec;
    logic [31:0] init_cnt_reg;
    logic covers_closed;
    logic covers_closed_reg;
    logic fault_reg;
    logic [15:0] code_reg;
    logic [4:0] count_reg;
    logic event_reg;
    logic [2:0] sel_a_reg;
    logic [2:0] sel_b_reg;
    logic permit_a_reg;
    logic permit_b_reg;
    logic duty_reg;

    // status lines cross in through three flops
    ihim_status_sync u_sync (
        .clk_i(SYS_CLK_I),
        .rstn_i(RSTN_I),
        .line_i({HEATER_STATUS_LINE_B_I, HEATER_STATUS_LINE_A_I}),
        .st(st)
    );

    // decode one status pattern for the check timing in force
    function automatic ihim_pkg::ihim_decode_s decode_status(
        input ihim_pkg::ihim_mode_e mode,
        input logic [1:0] pat
    );
        ihim_pkg::ihim_decode_s d;
        d = '{fault: 1'b0, code: `IHIM_CODE_NONE, count: `IHIM_CNT_ZERO};
        unique case (pat)
            `IHIM_PAT_HL:
                d.fault = 1'b0;
            `IHIM_PAT_LL:
            begin
                d.fault = 1'b1;
                unique case (mode)
                    ihim_pkg::IHIM_INIT:
                    begin
                        d.code = `IHIM_CODE_INIT;
                        d.count = `IHIM_CNT_INIT;
                    end
                    ihim_pkg::IHIM_RUN:
                    begin
                        d.code = `IHIM_CODE_SUPPLY;
                        d.count = `IHIM_CNT_SUPPLY;
                    end
                    default:
                    begin
                        d.code = `IHIM_CODE_COVER;
                        d.count = `IHIM_CNT_COVER;
                    end
                endcase
            end
            `IHIM_PAT_LH:
            begin
                d.fault = 1'b1;
                d.code = `IHIM_CODE_SWITCH;
                d.count = `IHIM_CNT_SWITCH;
            end
            `IHIM_PAT_HH:
            begin
                d.fault = 1'b1;
                d.code = `IHIM_CODE_CURRENT;
                d.count = `IHIM_CNT_CURRENT;
            end
        endcase
        return d;
    endfunction : decode_status

    // keep a counter value inside its legal range
    function automatic logic [4:0] clamp_count(input logic [4:0] c);
        return (c > `IHIM_CNT_MAX) ? `IHIM_CNT_MAX : c;
    endfunction : clamp_count

    // lower a power code by one 50 W step, never below the minimum
    function automatic logic [2:0] lower_power(input logic [2:0] p);
        return (p > `IHIM_POWER_MIN) ? p - `IHIM_POWER_STEP : `IHIM_POWER_MIN;
    endfunction : lower_power

    assign covers_closed = FRONT_COVER_CLOSED_I & JAM_COVER_CLOSED_I;
    assign dec = decode_status(mode_reg, st.level);

    // check timing selection
    always_comb
    begin
        mode_next = mode_reg;
        if (!covers_closed)
            mode_next = ihim_pkg::IHIM_COVER;
        else if (!covers_closed_reg)
            mode_next = ihim_pkg::IHIM_INIT;
        else if (mode_reg == ihim_pkg::IHIM_INIT
                 && init_cnt_reg >= 32'(INIT_CHECK_CYCLES - 1))
            mode_next = ihim_pkg::IHIM_RUN;
    end

    // check mode, starting in the power-up check
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RSTN_I)
        begin
            mode_reg <= ihim_pkg::IHIM_INIT;
            covers_closed_reg <= 1'b1;
        end
        else
        begin
            mode_reg <= mode_next;
            covers_closed_reg <= covers_closed;
        end
    end

    // length of the initialization check window
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RSTN_I)
            init_cnt_reg <= 32'h00000000;
        else if (mode_next != ihim_pkg::IHIM_INIT || mode_reg != ihim_pkg::IHIM_INIT)
            init_cnt_reg <= 32'h00000000;
        else
            init_cnt_reg <= init_cnt_reg + 32'h00000001;
    end

    // error latch; a new fault wins over a clear in the same cycle
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RSTN_I)
        begin
            fault_reg <= 1'b0;
            code_reg <= `IHIM_CODE_NONE;
            count_reg <= `IHIM_CNT_ZERO;
            event_reg <= 1'b0;
        end
        else
        begin
            event_reg <= 1'b0;
            if (dec.fault && (!fault_reg || ERR_CLEAR_I))
            begin
                fault_reg <= 1'b1;
                code_reg <= dec.code;
                count_reg <= clamp_count(dec.count);
                event_reg <= 1'b1;
            end
            else if (ERR_CLEAR_I)
            begin
                fault_reg <= 1'b0;
                code_reg <= `IHIM_CODE_NONE;
                count_reg <= `IHIM_CNT_ZERO;
            end
        end
    end

    // power setting codes per half, lowered while scanning in warm-up
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RSTN_I)
        begin
            sel_a_reg <= `IHIM_POWER_MIN;
            sel_b_reg <= `IHIM_POWER_MIN;
        end
        else if (WARM_UP_I && FEEDER_SCAN_I)
        begin
            sel_a_reg <= lower_power(HALF_A_POWER_LEVEL_I);
            sel_b_reg <= lower_power(HALF_B_POWER_LEVEL_I);
        end
        else
        begin
            sel_a_reg <= HALF_A_POWER_LEVEL_I;
            sel_b_reg <= HALF_B_POWER_LEVEL_I;
        end
    end

    // permits drop at once on a fault and stay low while latched
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RSTN_I)
        begin
            permit_a_reg <= 1'b0;
            permit_b_reg <= 1'b0;
        end
        else
        begin
            permit_a_reg <= HALF_A_HEAT_REQ_I & ~fault_reg & ~dec.fault;
            permit_b_reg <= HALF_B_HEAT_REQ_I & ~fault_reg & ~dec.fault;
        end
    end

    // duty ratio change line
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RSTN_I)
            duty_reg <= 1'b0;
        else
            duty_reg <= DUTY_CHANGE_I;
    end

    // outputs
    assign HALF_A_POWER_SEL_O = sel_a_reg;
    assign HALF_B_POWER_SEL_O = sel_b_reg;
    assign HALF_A_ENERGIZE_PERMIT_O = permit_a_reg;
    assign HALF_B_ENERGIZE_PERMIT_O = permit_b_reg;
    assign DUTY_CHANGE_REQUEST_O = duty_reg;
    assign SERVICE_CALL_O = fault_reg;
    assign ERROR_EVENT_O = event_reg;
    assign ERROR_CODE_O = code_reg;
    assign ERROR_COUNT_O = count_reg;
    assign CHECK_MODE_O = mode_reg;
endmodule : ihim_top

// >>> design/ihim_defines.svh
`ifndef IHIM_DEFINES_SVH
`define IHIM_DEFINES_SVH

// clock rate and initialization check window
`define IHIM_CLK_MHZ 25
`define IHIM_INIT_CHECK_US 10000

// status line patterns, bit 0 is line a, bit 1 is line b
`define IHIM_PAT_LL 2'h0
`define IHIM_PAT_HL 2'h1
`define IHIM_PAT_LH 2'h2
`define IHIM_PAT_HH 2'h3
`define IHIM_STATUS_RST 2'h1

// error codes, shown as four hex digits
`define IHIM_CODE_NONE 16'h0000
`define IHIM_CODE_INIT 16'hC471
`define IHIM_CODE_SUPPLY 16'hC472
`define IHIM_CODE_COVER 16'hC475
`define IHIM_CODE_SWITCH 16'hC480
`define IHIM_CODE_CURRENT 16'hC490

// error-status counter values
`define IHIM_CNT_ZERO 5'h00
`define IHIM_CNT_COVER 5'h0A
`define IHIM_CNT_INIT 5'h0B
`define IHIM_CNT_SUPPLY 5'h0C
`define IHIM_CNT_SWITCH 5'h0F
`define IHIM_CNT_CURRENT 5'h11
`define IHIM_CNT_MAX 5'h1D

// power setting code step worth 50 W
`define IHIM_POWER_STEP 3'h1
`define IHIM_POWER_MIN 3'h0

`endif

// >>> design/ihim_pkg.sv
package ihim_pkg;

    // when the status pattern is checked
    typedef enum logic [1:0] {
        IHIM_INIT,
        IHIM_RUN,
        IHIM_COVER
    } ihim_mode_e;

    // one decoded status
    typedef struct packed {
        logic fault;
        logic [15:0] code;
        logic [4:0] count;
    } ihim_decode_s;

endpackage : ihim_pkg

// >>> design/ihim_status_if.sv
`timescale 1ns/100ps
// filtered status pattern passed from the synchroniser to the monitor
interface ihim_status_if;
    logic [1:0] level;
    modport filt (output level);
    modport mon (input level);
endinterface : ihim_status_if

// >>> design/ihim_status_sync.sv
`timescale 1ns/100ps
`include "ihim_defines.svh"
module ihim_status_sync (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [1:0] line_i,
    ihim_status_if.filt st
);
    // idle level of the status pair, bit 0 is line a
    localparam logic [1:0] RST_LEVEL = `IHIM_STATUS_RST;
    logic [1:0] s1_reg;
    logic [1:0] s2_reg;
    logic [1:0] s3_reg;
    logic [1:0] level_reg;
    logic [1:0] level_next;

    // three flops per isolated status line
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_line
            always_ff @(posedge clk_i)
            begin
                if (!rstn_i)
                begin
                    s1_reg[g] <= RST_LEVEL[g];
                    s2_reg[g] <= RST_LEVEL[g];
                    s3_reg[g] <= RST_LEVEL[g];
                end
                else
                begin
                    s1_reg[g] <= line_i[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                end
            end
        end
    endgenerate

    // a line takes its new level once second and third stage agree
    assign level_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (level_reg & (s2_reg ^ s3_reg));

    // filtered status level
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            level_reg <= RST_LEVEL;
        else
            level_reg <= level_next;
    end

    assign st.level = level_reg;
endmodule : ihim_status_sync

// >>> test/ihim_checker.sv
`timescale 1ns/100ps
`include "ihim_defines.svh"
module ihim_checker (
    input wire logic SYS_CLK_I,
    input wire logic RSTN_I,
    input wire logic HEATER_STATUS_LINE_A_I,
    input wire logic HEATER_STATUS_LINE_B_I,
    input wire logic [2:0] HALF_A_POWER_LEVEL_I,
    input wire logic HALF_A_HEAT_REQ_I,
    input wire logic DUTY_CHANGE_I,
    input wire logic WARM_UP_I,
    input wire logic FEEDER_SCAN_I,
    input wire logic ERR_CLEAR_I,
    input wire logic [2:0] HALF_A_POWER_SEL_O,
    input wire logic HALF_A_ENERGIZE_PERMIT_O,
    input wire logic HALF_B_ENERGIZE_PERMIT_O,
    input wire logic DUTY_CHANGE_REQUEST_O,
    input wire logic SERVICE_CALL_O,
    input wire logic ERROR_EVENT_O,
    input wire logic [15:0] ERROR_CODE_O,
    input wire logic [4:0] ERROR_COUNT_O,
    input wire logic [1:0] CHECK_MODE_O
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RSTN_I);
    // both lines low for five edges while running with nothing latched
    sequence s_supply_loss;
        (CHECK_MODE_O == 2'h1 && !HEATER_STATUS_LINE_A_I && !HEATER_STATUS_LINE_B_I
            && !SERVICE_CALL_O && !ERR_CLEAR_I) [*5];
    endsequence
    a_supply_latch: assert property (s_supply_loss |=> SERVICE_CALL_O)
        else $error("supply loss not latched");
    a_permit_cause: assert property (HALF_A_ENERGIZE_PERMIT_O |-> $past(HALF_A_HEAT_REQ_I))
        else $error("permit without request");
    a_fault_cuts: assert property (SERVICE_CALL_O |-> !HALF_A_ENERGIZE_PERMIT_O
        && !HALF_B_ENERGIZE_PERMIT_O) else $error("permit while fault latched");
    a_count_range: assert property (ERROR_COUNT_O <= `IHIM_CNT_MAX)
        else $error("counter out of range");
    a_event_pulse: assert property (ERROR_EVENT_O |-> SERVICE_CALL_O ##1 !ERROR_EVENT_O)
        else $error("event pulse malformed");
    a_latch_hold: assert property (SERVICE_CALL_O && !ERR_CLEAR_I |=> SERVICE_CALL_O
        && $stable(ERROR_CODE_O)) else $error("latched error changed");
    a_duty_copy: assert property (1'b1 |=> DUTY_CHANGE_REQUEST_O == $past(DUTY_CHANGE_I))
        else $error("duty request mismatch");
    a_power_pass: assert property (!(WARM_UP_I && FEEDER_SCAN_I) |=>
        HALF_A_POWER_SEL_O == $past(HALF_A_POWER_LEVEL_I)) else $error("power code mismatch");
    a_power_trim: assert property (WARM_UP_I && FEEDER_SCAN_I && HALF_A_POWER_LEVEL_I != 3'h0
        |=> HALF_A_POWER_SEL_O == $past(HALF_A_POWER_LEVEL_I) - `IHIM_POWER_STEP)
        else $error("power code not lowered");
endmodule : ihim_checker

// >>> test/ihim_heater_model.sv
`timescale 1ns/100ps
`include "ihim_defines.svh"
module ihim_heater_model #(
    parameter int ON_LIMIT = 30
) (
    input wire logic clk_i,
    input wire logic permit_a_i,
    input wire logic permit_b_i,
    input wire logic [1:0] pat_i,
    output logic line_a_o,
    output logic line_b_o
);
    int on_a = 0;
    int on_b = 0;
    // time how long each coil half has conducted without a break
    always @(posedge clk_i)
    begin
        on_a <= permit_a_i ? on_a + 1 : 0;
        on_b <= permit_b_i ? on_b + 1 : 0;
    end
    // long conduction reports the switch fault pattern, levels cross the isolator as is
    assign {line_b_o, line_a_o} = (on_a >= ON_LIMIT || on_b >= ON_LIMIT) ?
        `IHIM_PAT_LH : pat_i;
endmodule : ihim_heater_model

// >>> test/ihim_top_tb_top.sv
`timescale 1ns/100ps
`include "ihim_defines.svh"
module ihim_top_tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic jc = 1'b1;
    logic fc = 1'b1;
    logic rqa = 1'b0;
    logic rqb = 1'b0;
    logic duty = 1'b0;
    logic warm = 1'b0;
    logic scan = 1'b0;
    logic clr = 1'b0;
    logic [2:0] lva = 3'h0;
    logic [2:0] lvb = 3'h0;
    logic [1:0] pat = `IHIM_PAT_HL;
    logic la, lb, pa, pb, dr, svc, ev;
    logic [2:0] sa, sb;
    logic [15:0] code;
    logic [4:0] cnt;
    logic [1:0] mode;
    int n_errors = 0;
    int comparisons = 0;
    ihim_top #(.INIT_CHECK_CYCLES(20)) i_dut (.SYS_CLK_I(clk), .RSTN_I(rstn),
        .HEATER_STATUS_LINE_A_I(la), .HEATER_STATUS_LINE_B_I(lb), .FRONT_COVER_CLOSED_I(fc),
        .JAM_COVER_CLOSED_I(jc), .HALF_A_POWER_LEVEL_I(lva), .HALF_B_POWER_LEVEL_I(lvb),
        .HALF_A_HEAT_REQ_I(rqa), .HALF_B_HEAT_REQ_I(rqb), .DUTY_CHANGE_I(duty),
        .WARM_UP_I(warm), .FEEDER_SCAN_I(scan), .ERR_CLEAR_I(clr), .HALF_A_POWER_SEL_O(sa),
        .HALF_B_POWER_SEL_O(sb), .HALF_A_ENERGIZE_PERMIT_O(pa), .HALF_B_ENERGIZE_PERMIT_O(pb),
        .DUTY_CHANGE_REQUEST_O(dr), .SERVICE_CALL_O(svc), .ERROR_EVENT_O(ev),
        .ERROR_CODE_O(code), .ERROR_COUNT_O(cnt), .CHECK_MODE_O(mode));
    ihim_heater_model i_board (.clk_i(clk), .permit_a_i(pa), .permit_b_i(pb), .pat_i(pat),
        .line_a_o(la), .line_b_o(lb));
    // free running system clock
    initial
    begin
        forever #20 clk = ~clk;
    end
    // expected power code, one step lower while warming up with feeder scanning
    function automatic logic [2:0] exp_sel(input logic [2:0] l, input logic t);
        return (t && l != `IHIM_POWER_MIN) ? l - `IHIM_POWER_STEP : l;
    endfunction : exp_sel
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // three edges of reset; every synchroniser stage resets directly
    task automatic do_reset();
        rstn = 1'b0;
        tick(3);
        rstn = 1'b1;
        tick(1);
        chk({11'h0, cnt}, 16'h0);
    endtask : do_reset
    task automatic wait_svc();
        int i;
        for (i = 0; i < 60 && svc !== 1'b1; i++)
            tick(1);
        if (i == 60)
        begin
            n_errors++;
            results();
        end
    endtask : wait_svc
    // latch one fault in a given check mode, prove it holds, then repair and clear
    task automatic run_case(input int m, input logic [1:0] p, input logic [15:0] ec,
        input logic [4:0] cc);
        pat = (m == 0) ? p : `IHIM_PAT_HL;
        do_reset();
        if (m != 0)
            tick(25);
        jc = (m != 2);
        fc = (m != 3);
        tick(1);
        chk({14'h0, mode}, (m == 4) ? 16'h1 : (m == 3) ? 16'h2 : 16'(m));
        pat = p;
        rqa = 1'b1;
        wait_svc();
        chk({15'h0, ev}, 16'h1);
        chk(code, ec);
        chk({11'h0, cnt}, {11'h0, cc});
        chk({14'h0, pa, pb}, 16'h0);
        pat = `IHIM_PAT_HH;
        tick(8);
        chk({14'h0, svc, ev}, 16'h2);
        chk(code, ec);
        pat = `IHIM_PAT_HL;
        rqa = 1'b0;
        jc = 1'b1;
        fc = 1'b1;
        tick(8);
        if (m == 2 || m == 3)
            chk({14'h0, mode}, 16'h0);
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        chk({10'h0, svc, cnt}, 16'h0);
        chk(code, `IHIM_CODE_NONE);
    endtask : run_case
    initial
    begin
        void'($urandom(32'h58EC));
        do_reset();
        tick(25);
        for (int k = 0; k < 40; k++)
        begin
            lva = (k == 0) ? 3'h0 : 3'($urandom);
            lvb = 3'($urandom);
            warm = (k < 2) | 1'($urandom);
            scan = (k < 2) | 1'($urandom);
            duty = 1'($urandom);
            rqa = 1'($urandom);
            rqb = 1'($urandom);
            tick(1);
            chk({13'h0, sa}, {13'h0, exp_sel(lva, warm && scan)});
            chk({13'h0, sb}, {13'h0, exp_sel(lvb, warm && scan)});
            chk({13'h0, dr, pa, pb}, {13'h0, duty, rqa, rqb});
        end
        rqa = 1'b0;
        rqb = 1'b0;
        run_case(0, `IHIM_PAT_LL, `IHIM_CODE_INIT, `IHIM_CNT_INIT);
        run_case(1, `IHIM_PAT_LL, `IHIM_CODE_SUPPLY, `IHIM_CNT_SUPPLY);
        run_case(1, `IHIM_PAT_HH, `IHIM_CODE_CURRENT, `IHIM_CNT_CURRENT);
        run_case(2, `IHIM_PAT_LL, `IHIM_CODE_COVER, `IHIM_CNT_COVER);
        run_case(3, `IHIM_PAT_LL, `IHIM_CODE_COVER, `IHIM_CNT_COVER);
        run_case(4, `IHIM_PAT_HL, `IHIM_CODE_SWITCH, `IHIM_CNT_SWITCH);
        // a latched fault must not survive a power-up once repaired
        tick(25);
        pat = `IHIM_PAT_LL;
        wait_svc();
        pat = `IHIM_PAT_HL;
        do_reset();
        results();
    end
endmodule : ihim_top_tb_top
bind ihim_top ihim_checker i_chk (.SYS_CLK_I, .RSTN_I, .HEATER_STATUS_LINE_A_I,
    .HEATER_STATUS_LINE_B_I, .HALF_A_POWER_LEVEL_I, .HALF_A_HEAT_REQ_I, .DUTY_CHANGE_I,
    .WARM_UP_I, .FEEDER_SCAN_I, .ERR_CLEAR_I, .HALF_A_POWER_SEL_O, .HALF_A_ENERGIZE_PERMIT_O,
    .HALF_B_ENERGIZE_PERMIT_O, .DUTY_CHANGE_REQUEST_O, .SERVICE_CALL_O, .ERROR_EVENT_O,
    .ERROR_CODE_O, .ERROR_COUNT_O, .CHECK_MODE_O);
